// ---- logic/tamper_selftest_supervisor.sv ----
// Tamper latch, self-test sequencer and one-way keyboard and pointer data gate.
`timescale 1ns/100ps
module tamper_selftest_supervisor
    import supervisor_pkg::*;
(
    // Clock and main reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Backup-powered tamper domain
    input wire logic tamper_sense,
    input wire logic backup_fail,
    input wire logic tamper_latched_in,
    output logic tamper_latch_set,
    // Self-test results
    input wire logic [NUM_TESTS-1:0] test_fail,
    // Peripheral side
    input wire logic kbd_valid,
    input wire logic [DATA_W-1:0] kbd_data,
    input wire logic ptr_valid,
    input wire logic [DATA_W-1:0] ptr_data,
    input wire logic [HOST_SEL_W-1:0] host_sel,
    // Access request on external ports
    input wire logic access_req,
    output logic access_deny,
    // Host side
    output logic [NUM_HOSTS-1:0] host_kbd_valid,
    output logic [DATA_W-1:0] host_kbd_data,
    output logic [NUM_HOSTS-1:0] host_ptr_valid,
    output logic [DATA_W-1:0] host_ptr_data,
    // Peripheral-side return path
    output logic periph_tx_en,
    // Indicators
    output logic tamper_led,
    output logic fail_led,
    output logic running
);
    sup_state_e state;
    logic tampered;
    logic [TEST_CNT_W-1:0] test_cnt;
    logic [NUM_TESTS-1:0] failed;
    logic test_done;
    logic next_tamper_set;

    // ********************************
    // Tamper latch
    // ********************************
    // The sticky bit lives in the backup domain; here we only request its set and read it back.
    assign next_tamper_set = tamper_sense | backup_fail;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tamper_latch_set <= 1'b0;
        end else begin
            tamper_latch_set <= next_tamper_set;
        end
    end
    // Reset cannot clear this: it follows the backup-held latch and sets on any local event.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tampered <= 1'b1;
        end else if (tamper_latched_in || next_tamper_set) begin
            tampered <= 1'b1;
        end else if (state == ST_TEST) begin
            tampered <= 1'b0;
        end
    end

    // ********************************
    // Self-test sequencer
    // ********************************
    assign test_done = (test_cnt == TEST_LAST);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            test_cnt <= '0;
        end else if (state == ST_TEST && !test_done) begin
            test_cnt <= test_cnt + 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            failed <= FAIL_RST;
        end else if (state == ST_TEST) begin
            failed <= failed | test_fail;
        end
    end
    // Test 0 covers the core; its failure stops the whole device, tests 1 and 2 only their channel, test 3 stops nothing.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_TEST;
        end else begin
            unique case (state)
                ST_TEST: begin
                    if (test_done) begin
                        state <= (failed[0] || test_fail[0]) ? ST_FAILED : ST_RUN;
                    end
                end
                ST_RUN: state <= ST_RUN;
                ST_FAILED: state <= ST_FAILED;
                // An upset could leave the unused code behind, so it falls to the safe failed state.
                default: state <= ST_FAILED;
            endcase
        end
    end

    // ********************************
    // One-way data gate
    // ********************************
    // One decoder serves both channels so keyboard and pointer always steer to the same computer.
    function automatic logic host_hit(input logic [HOST_SEL_W-1:0] sel, input int unsigned idx);
        return sel == HOST_SEL_W'(idx);
    endfunction

    logic kbd_ok;
    logic ptr_ok;
    assign kbd_ok = (state == ST_RUN) && !tampered && !failed[1];
    assign ptr_ok = (state == ST_RUN) && !tampered && !failed[2];
    genvar h;
    generate
        for (h = 0; h < NUM_HOSTS; h++) begin : g_host
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    host_kbd_valid[h] <= 1'b0;
                    host_ptr_valid[h] <= 1'b0;
                end else begin
                    host_kbd_valid[h] <= kbd_ok && kbd_valid && host_hit(host_sel, h);
                    host_ptr_valid[h] <= ptr_ok && ptr_valid && host_hit(host_sel, h);
                end
            end
        end
    endgenerate
    // Data words are re-registered so no combinational path joins peripheral and host.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            host_kbd_data <= DATA_RST;
            host_ptr_data <= DATA_RST;
        end else begin
            host_kbd_data <= kbd_ok ? kbd_data : DATA_RST;
            host_ptr_data <= ptr_ok ? ptr_data : DATA_RST;
        end
    end

    // ********************************
    // Indicators and refusals
    // ********************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            periph_tx_en <= 1'b0;
            access_deny <= 1'b0;
            tamper_led <= 1'b0;
            fail_led <= 1'b0;
            running <= 1'b0;
        end else begin
            periph_tx_en <= 1'b0;
            access_deny <= access_req;
            tamper_led <= tampered;
            fail_led <= (failed != FAIL_RST) || (state == ST_FAILED);
            running <= kbd_ok || ptr_ok;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    a_tamper_blocks_kbd: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> host_kbd_valid == '0)
        else $error("keyboard data passed while tampered");

    a_tamper_blocks_ptr: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> host_ptr_valid == '0)
        else $error("pointer data passed while tampered");

    a_tamper_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tampered && state != ST_TEST) |=> tampered)
        else $error("tamper latch cleared");

    a_backup_fail_trip: assert property (@(posedge sys_clk) disable iff (!nrst)
        backup_fail |=> tampered ##1 tamper_led)
        else $error("backup failure not latched");

    a_tamper_led_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> tamper_led)
        else $error("tamper indicator dark");

    a_tamper_led_dark: assert property (@(posedge sys_clk) disable iff (!nrst)
        !tampered |=> !tamper_led)
        else $error("tamper indicator lit without tamper");

    a_latch_req_set: assert property (@(posedge sys_clk) disable iff (!nrst)
        (tamper_sense || backup_fail) |=> tamper_latch_set)
        else $error("backup latch not asked to set");

    a_latch_req_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(tamper_sense || backup_fail) |=> !tamper_latch_set)
        else $error("backup latch asked to set without cause");

    a_sense_trips: assert property (@(posedge sys_clk) disable iff (!nrst)
        tamper_sense |=> tampered)
        else $error("tamper event not latched");

    a_hold_tamper_in: assert property (@(posedge sys_clk) disable iff (!nrst)
        tamper_latched_in |=> tampered ##1 !running)
        else $error("backup latch ignored");

    a_tamper_no_running: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> !running)
        else $error("running while tampered");

    a_tamper_kbd_data: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> host_kbd_data == DATA_RST)
        else $error("keyboard word shown while tampered");

    a_tamper_ptr_data: assert property (@(posedge sys_clk) disable iff (!nrst)
        tampered |=> host_ptr_data == DATA_RST)
        else $error("pointer word shown while tampered");

    // ********************************
    // Self-test and indicator checks
    // ********************************
    a_test_before_run: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST) |=> !running)
        else $error("data flow during self-test");

    a_run_needs_state: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state != ST_RUN) |=> !running)
        else $error("running outside run state");

    a_test_count_step: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST && !test_done) |=> test_cnt == $past(test_cnt) + 10'h001)
        else $error("self-test counter stalled");

    a_test_stays: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST && !test_done) |=> state == ST_TEST)
        else $error("self-test left early");

    a_test_ends: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST && test_done) |=> state != ST_TEST)
        else $error("self-test never ends");

    a_core_fail_state: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST && test_done && test_fail[0]) |=> state == ST_FAILED)
        else $error("core failure not latched");

    a_core_fail_stops: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_FAILED) |=> (host_kbd_valid == '0 && host_ptr_valid == '0))
        else $error("data flow after core failure");

    a_kbd_fail_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
        failed[1] |=> host_kbd_valid == '0)
        else $error("keyboard flow after channel failure");

    a_ptr_fail_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
        failed[2] |=> host_ptr_valid == '0)
        else $error("pointer flow after channel failure");

    a_fail_led_on: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state == ST_TEST && test_fail != '0) |=> ##1 fail_led)
        else $error("failure not shown");

    a_fail_led_held: assert property (@(posedge sys_clk) disable iff (!nrst)
        (failed != FAIL_RST) |=> fail_led)
        else $error("failure indicator dropped");

    a_fail_led_dark: assert property (@(posedge sys_clk) disable iff (!nrst)
        (failed == FAIL_RST && state != ST_FAILED) |=> !fail_led)
        else $error("failure indicator lit without failure");

    // ********************************
    // Data gate and refusal checks
    // ********************************
    a_no_return_path: assert property (@(posedge sys_clk) disable iff (!nrst)
        !periph_tx_en)
        else $error("return path enabled");

    a_access_refused: assert property (@(posedge sys_clk) disable iff (!nrst)
        access_req |=> access_deny)
        else $error("access request not refused");

    a_access_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
        !access_req |=> !access_deny)
        else $error("refusal without request");

    a_one_host_kbd: assert property (@(posedge sys_clk) disable iff (!nrst)
        $onehot0(host_kbd_valid))
        else $error("keyboard word sent to several computers");

    a_one_host_ptr: assert property (@(posedge sys_clk) disable iff (!nrst)
        $onehot0(host_ptr_valid))
        else $error("pointer word sent to several computers");

    a_kbd_route: assert property (@(posedge sys_clk) disable iff (!nrst)
        (kbd_valid && kbd_ok) |=> host_kbd_valid == (4'h1 << $past(host_sel)))
        else $error("keyboard word sent to wrong computer");

    a_kbd_word: assert property (@(posedge sys_clk) disable iff (!nrst)
        (kbd_valid && kbd_ok) |=> host_kbd_data == $past(kbd_data))
        else $error("keyboard word altered");
endmodule

// ---- logic/supervisor_pkg.sv ----
// Constants and types shared by the tamper and self-test supervisor.
package supervisor_pkg;
    // ********************************
    // Widths and counts
    // ********************************
    localparam int unsigned NUM_HOSTS = 4;
    localparam int unsigned HOST_SEL_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_TESTS = 4;
    localparam int unsigned TEST_TIME_US = 10;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned TEST_CYCLES = TEST_TIME_US * CLK_MHZ;
    localparam int unsigned TEST_CNT_W = 10;
    localparam logic [TEST_CNT_W-1:0] TEST_LAST = 10'(TEST_CYCLES - 1);
    // ********************************
    // Reset values and state type
    // ********************************
    localparam logic [NUM_TESTS-1:0] FAIL_RST = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    typedef enum logic [1:0] {ST_TEST, ST_RUN, ST_FAILED} sup_state_e;
endpackage

// ---- tb/backup_latch.sv ----
// Behavioural model of the backup-powered sticky tamper latch.
`timescale 1ns/100ps
module backup_latch (
    // Clock and set request
    input wire logic sys_clk,
    input wire logic set_req,
    // Readback toward the supervisor
    output logic latched
);
    // The latch runs from its own supply, so the main reset never clears it.
    initial latched = 1'b0;
    always @(posedge sys_clk) begin
        if (set_req === 1'b1) begin
            latched <= 1'b1;
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the tamper and self-test supervisor.
`timescale 1ns/100ps
module testbench;
    import supervisor_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0, tamper_sense = 1'b0, backup_fail = 1'b0;
    logic tamper_latched_in, tamper_latch_set, access_deny, periph_tx_en, tamper_led, fail_led, running;
    logic kbd_valid = 1'b0, ptr_valid = 1'b0, access_req = 1'b0;
    logic [NUM_TESTS-1:0] test_fail = 4'h0;
    logic [DATA_W-1:0] kbd_data = 8'h00, ptr_data = 8'h00, host_kbd_data, host_ptr_data, pkd, ppd;
    logic [HOST_SEL_W-1:0] host_sel = 2'h0, ps;
    logic [NUM_HOSTS-1:0] host_kbd_valid, host_ptr_valid;
    logic en_k = 1'b0, en_p = 1'b0, pk = 1'b0, pp = 1'b0, pa = 1'b0;
    logic [3:0] tfs [5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h1};
    int fails = 0, cmp_count = 0, cycles = 0;
    int seed = 32'h84d63594;
    tamper_selftest_supervisor DUT (.sys_clk, .nrst, .tamper_sense, .backup_fail, .tamper_latched_in,
        .tamper_latch_set, .test_fail, .kbd_valid, .kbd_data, .ptr_valid, .ptr_data, .host_sel, .access_req,
        .access_deny, .host_kbd_valid, .host_kbd_data, .host_ptr_valid, .host_ptr_data, .periph_tx_en,
        .tamper_led, .fail_led, .running);
    backup_latch partner (.sys_clk(sys_clk), .set_req(tamper_latch_set), .latched(tamper_latched_in));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // A hung run is cut short long after the longest sequence should end.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ********************************
    // Random words, checked one cycle later
    // ********************************
    task automatic traffic(input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge sys_clk);
            #1;
            chk(host_kbd_valid, 8'(pk & en_k) << ps);
            if (pk & en_k) chk(host_kbd_data, pkd);
            chk(host_ptr_valid, 8'(pp & en_p) << ps);
            if (pp & en_p) chk(host_ptr_data, ppd);
            chk(8'(access_deny), 8'(pa));
            chk(8'(periph_tx_en), 8'h00);
            if (i < n) begin
                {kbd_valid, ptr_valid, access_req} = 3'($random(seed));
                {kbd_data, ptr_data, host_sel} = 18'($random(seed));
            end else begin
                {kbd_valid, ptr_valid, access_req} = 3'h0;
            end
            {pk, pp, pa, pkd, ppd, ps} = {kbd_valid, ptr_valid, access_req, kbd_data, ptr_data, host_sel};
        end
    endtask
    // Words offered during self-test must all be dropped.
    task automatic start_up(input logic [3:0] tf, input logic run_exp);
        nrst = 1'b0;
        test_fail = tf;
        {en_k, en_p} = 2'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({running, tamper_led, fail_led}, 8'h00);
        nrst = 1'b1;
        traffic(450);
        {pk, pp, pa} = 3'h0;
        for (int i = 0; i < 150 && running !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(8'(running), 8'(run_exp));
        chk(8'(fail_led), 8'(tf != 4'h0));
        en_k = run_exp & !tf[1];
        en_p = run_exp & !tf[2];
    endtask
    initial begin
        foreach (tfs[j]) begin
            start_up(tfs[j], !tfs[j][0]);
            traffic(200);
            chk(8'(tamper_led), 8'h00);
        end
        start_up(4'h0, 1'b1);
        traffic(50);
        tamper_sense = 1'b1;
        @(posedge sys_clk);
        #1;
        tamper_sense = 1'b0;
        chk(8'(tamper_latch_set), 8'h01);
        {en_k, en_p} = 2'h0;
        traffic(30);
        chk(8'(tamper_led), 8'h01);
        start_up(4'h0, 1'b0);
        chk(8'(tamper_led), 8'h01);
        traffic(100);
        backup_fail = 1'b1;
        @(posedge sys_clk);
        #1;
        chk(8'(tamper_latch_set), 8'h01);
        test_done();
    end
endmodule
